//--- jtt_defs.svh
// Constants for the test access port controller
`ifndef JTT_DEFS_SVH
`define JTT_DEFS_SVH

// ****************************************
// Instruction register
// ****************************************
`define JTT_IR_W 3
`define JTT_IR_EXTEST 3'h0
`define JTT_IR_IDCODE 3'h1
`define JTT_IR_SAMPLE 3'h2
`define JTT_IR_CLAMP 3'h3
`define JTT_IR_HIGHZ 3'h4
`define JTT_IR_BYPASS 3'h7
// Fixed pattern loaded on instruction capture
`define JTT_IR_CAPTURE 3'h1

// ****************************************
// Data registers
// ****************************************
`define JTT_BSR_W 126
`define JTT_ID_W 32
// Identification fields, values arbitrary
`define JTT_ID_VERSION 4'h0
`define JTT_ID_PART 16'h5a5a
`define JTT_ID_MAKER 11'h2aa
`define JTT_ID_LSB 1'h1

`endif

//--- jtt_pkg.sv
// Types for the test access port controller
package jtt_pkg;

  // One-hot controller states
  typedef enum logic [15:0] {
    JTT_TLR    = 16'h0001,
    JTT_RTI    = 16'h0002,
    JTT_SEL_DR = 16'h0004,
    JTT_CAP_DR = 16'h0008,
    JTT_SH_DR  = 16'h0010,
    JTT_EX1_DR = 16'h0020,
    JTT_PA_DR  = 16'h0040,
    JTT_EX2_DR = 16'h0080,
    JTT_UPD_DR = 16'h0100,
    JTT_SEL_IR = 16'h0200,
    JTT_CAP_IR = 16'h0400,
    JTT_SH_IR  = 16'h0800,
    JTT_EX1_IR = 16'h1000,
    JTT_PA_IR  = 16'h2000,
    JTT_EX2_IR = 16'h4000,
    JTT_UPD_IR = 16'h8000
  } jtt_state_t;

endpackage

//--- jtt_scan_reg.sv
// Scan register with shift path and falling-edge update latch
`timescale 1ns/1ps
`default_nettype none

module jtt_scan_reg #(
  parameter int W = 126
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Controls
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  // Data
  input wire logic ser_i,
  input wire logic [W-1:0] par_i,
  output logic ser_o,
  output logic [W-1:0] par_o
);

  logic [W-1:0] sh;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh <= '0;
    end else if (capture_i) begin
      sh <= par_i;
    end else if (shift_i) begin
      sh <= {ser_i, sh[W-1:1]};
    end
  end

  // Parallel outputs only move on the falling edge, never while shifting
  always_ff @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_o <= '0;
    end else if (update_i) begin
      par_o <= sh;
    end
  end

  assign ser_o = sh[0];

endmodule
`default_nettype wire

//--- jtt_tap.sv
// Test access port controller with instruction and data registers
// Function
// - State moves on rising test clock only
// - Power-up in reset state, IDCODE current
// - Run-idle holds all test registers
// - Select-DR holds; low capture, high select-IR
// - Capture-DR loads selected register, then shift/exit
// - Shift-DR shifts selected register toward output
// - Exit1-DR high update, low pause
// - Pause-DR holds while low, high exit2
// - Exit2-DR high update, low shift
// - Update-DR latches on falling edge
// - Select-IR holds; low capture, high reset
// - Capture-IR loads fixed pattern
// - Shift-IR shifts instruction, others hold
// - Exit1-IR low pause, high update
// - Pause-IR holds while low, high exit2
// - Update-IR latches instruction on falling edge
// - Decode six public instructions
// - Port works only with feature select low
// - Three-bit instruction register with latch
// - Fixed instruction codes
// - One-bit bypass for bypass, clamp, highz
// - 32-bit identification with fixed fields
`timescale 1ns/1ps
`default_nettype none
`include "jtt_defs.svh"

module jtt_tap #(
  parameter int BSR_W = `JTT_BSR_W,
  parameter logic [3:0] ID_VERSION = `JTT_ID_VERSION,
  parameter logic [15:0] ID_PART = `JTT_ID_PART,
  parameter logic [10:0] ID_MAKER = `JTT_ID_MAKER
) (
  // System clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Test port
  input wire logic test_clock,
  input wire logic test_reset_n,
  input wire logic test_mode_select,
  input wire logic test_serial_in,
  output logic test_serial_out_o,
  output logic test_serial_out_en_n_o,
  // Strap
  input wire logic feature_set_select_i,
  // Boundary pins, system side
  input wire logic [BSR_W-1:0] pin_sample_i,
  output logic [BSR_W-1:0] pin_data_o,
  output logic pin_drive_o,
  output logic pin_highz_o
);

  // ****************************************
  // Reset and strap
  // ****************************************
  // Either power-up or the test reset pin returns the port to the reset state
  wire tap_rst_n = test_reset_n & nrst_i;

  logic fss_s1;
  logic fss_s2;

  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      fss_s1 <= 1'b1;
      fss_s2 <= 1'b1;
    end else begin
      fss_s1 <= feature_set_select_i;
      fss_s2 <= fss_s1;
    end
  end

  // ****************************************
  // Controller
  // ****************************************
  jtt_pkg::jtt_state_t state;
  jtt_pkg::jtt_state_t next_state;
  wire tms = test_mode_select;

  always_comb begin
    case (state)
      jtt_pkg::JTT_TLR:
        next_state = tms ? jtt_pkg::JTT_TLR : jtt_pkg::JTT_RTI;
      jtt_pkg::JTT_RTI:
        next_state = tms ? jtt_pkg::JTT_SEL_DR : jtt_pkg::JTT_RTI;
      jtt_pkg::JTT_SEL_DR:
        next_state = tms ? jtt_pkg::JTT_SEL_IR : jtt_pkg::JTT_CAP_DR;
      jtt_pkg::JTT_CAP_DR:
        next_state = tms ? jtt_pkg::JTT_EX1_DR : jtt_pkg::JTT_SH_DR;
      jtt_pkg::JTT_SH_DR:
        next_state = tms ? jtt_pkg::JTT_EX1_DR : jtt_pkg::JTT_SH_DR;
      jtt_pkg::JTT_EX1_DR:
        next_state = tms ? jtt_pkg::JTT_UPD_DR : jtt_pkg::JTT_PA_DR;
      jtt_pkg::JTT_PA_DR:
        next_state = tms ? jtt_pkg::JTT_EX2_DR : jtt_pkg::JTT_PA_DR;
      jtt_pkg::JTT_EX2_DR:
        next_state = tms ? jtt_pkg::JTT_UPD_DR : jtt_pkg::JTT_SH_DR;
      jtt_pkg::JTT_UPD_DR:
        next_state = tms ? jtt_pkg::JTT_SEL_DR : jtt_pkg::JTT_RTI;
      jtt_pkg::JTT_SEL_IR:
        next_state = tms ? jtt_pkg::JTT_TLR : jtt_pkg::JTT_CAP_IR;
      jtt_pkg::JTT_CAP_IR:
        next_state = tms ? jtt_pkg::JTT_EX1_IR : jtt_pkg::JTT_SH_IR;
      jtt_pkg::JTT_SH_IR:
        next_state = tms ? jtt_pkg::JTT_EX1_IR : jtt_pkg::JTT_SH_IR;
      jtt_pkg::JTT_EX1_IR:
        next_state = tms ? jtt_pkg::JTT_UPD_IR : jtt_pkg::JTT_PA_IR;
      jtt_pkg::JTT_PA_IR:
        next_state = tms ? jtt_pkg::JTT_EX2_IR : jtt_pkg::JTT_PA_IR;
      jtt_pkg::JTT_EX2_IR:
        next_state = tms ? jtt_pkg::JTT_UPD_IR : jtt_pkg::JTT_SH_IR;
      jtt_pkg::JTT_UPD_IR:
        next_state = tms ? jtt_pkg::JTT_SEL_DR : jtt_pkg::JTT_RTI;
      default:
        next_state = jtt_pkg::JTT_TLR;
    endcase
  end

  // Strap high parks the port in reset, emulating the older part
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state <= jtt_pkg::JTT_TLR;
    end else if (fss_s2) begin
      state <= jtt_pkg::JTT_TLR;
    end else begin
      state <= next_state;
    end
  end

  wire in_tlr = (state == jtt_pkg::JTT_TLR);
  wire cap_dr = (state == jtt_pkg::JTT_CAP_DR);
  wire sh_dr = (state == jtt_pkg::JTT_SH_DR);
  wire upd_dr = (state == jtt_pkg::JTT_UPD_DR);
  wire cap_ir = (state == jtt_pkg::JTT_CAP_IR);
  wire sh_ir = (state == jtt_pkg::JTT_SH_IR);
  wire upd_ir = (state == jtt_pkg::JTT_UPD_IR);

  // ****************************************
  // Instruction register
  // ****************************************
  logic [`JTT_IR_W-1:0] ir_shift;
  logic [`JTT_IR_W-1:0] ir_cur;

  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_shift <= `JTT_IR_CAPTURE;
    end else if (cap_ir) begin
      ir_shift <= `JTT_IR_CAPTURE;
    end else if (sh_ir) begin
      ir_shift <= {test_serial_in, ir_shift[`JTT_IR_W-1:1]};
    end
  end

  // Current instruction changes only on the falling edge
  always_ff @(negedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_cur <= `JTT_IR_IDCODE;
    end else if (in_tlr) begin
      ir_cur <= `JTT_IR_IDCODE;
    end else if (upd_ir) begin
      ir_cur <= ir_shift;
    end
  end

  // ****************************************
  // Instruction decode
  // ****************************************
  wire op_extest = (ir_cur == `JTT_IR_EXTEST);
  wire op_sample = (ir_cur == `JTT_IR_SAMPLE);
  wire op_idcode = (ir_cur == `JTT_IR_IDCODE);
  wire op_clamp = (ir_cur == `JTT_IR_CLAMP);
  wire op_highz = (ir_cur == `JTT_IR_HIGHZ);
  // Unassigned codes fall back to the short path
  wire sel_bsr = op_extest | op_sample;
  wire sel_id = op_idcode;
  wire sel_byp = ~(sel_bsr | sel_id);

  // ****************************************
  // Data registers
  // ****************************************
  logic byp;
  logic [`JTT_ID_W-1:0] id_shift;
  logic bsr_ser;
  logic [BSR_W-1:0] bsr_par;
  logic [BSR_W-1:0] pin_s1;
  logic [BSR_W-1:0] pin_s2;

  wire [`JTT_ID_W-1:0] id_value =
    {ID_VERSION, ID_PART, ID_MAKER, `JTT_ID_LSB};

  // Bypass captures zero so a chain count is possible
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      byp <= 1'b0;
    end else if (sel_byp && cap_dr) begin
      byp <= 1'b0;
    end else if (sel_byp && sh_dr) begin
      byp <= test_serial_in;
    end
  end

  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_shift <= '0;
    end else if (sel_id && cap_dr) begin
      id_shift <= id_value;
    end else if (sel_id && sh_dr) begin
      id_shift <= {test_serial_in, id_shift[`JTT_ID_W-1:1]};
    end
  end

  // Pin levels come from outside the test clock domain
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= pin_sample_i;
      pin_s2 <= pin_s1;
    end
  end

  jtt_scan_reg #(
    .W(BSR_W)
  ) u_bsr (
    .clk_i(test_clock),
    .rst_n_i(tap_rst_n),
    .capture_i(sel_bsr & cap_dr),
    .shift_i(sel_bsr & sh_dr),
    .update_i(sel_bsr & upd_dr),
    .ser_i(test_serial_in),
    .par_i(pin_s2),
    .ser_o(bsr_ser),
    .par_o(bsr_par)
  );

  // ****************************************
  // Serial output
  // ****************************************
  wire dr_out = sel_bsr ? bsr_ser : (sel_id ? id_shift[0] : byp);
  wire tdo_next = sh_ir ? ir_shift[0] : dr_out;

  // Launched on the falling edge so the tester samples a settled bit
  always_ff @(negedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      test_serial_out_o <= 1'b0;
      test_serial_out_en_n_o <= 1'b1;
    end else begin
      test_serial_out_o <= tdo_next;
      test_serial_out_en_n_o <= ~(sh_ir | sh_dr);
    end
  end

  // ****************************************
  // Modes and update toward system clock
  // ****************************************
  logic mode_drive;
  logic mode_hiz;
  logic upd_tgl;

  always_ff @(negedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      mode_drive <= 1'b0;
      mode_hiz <= 1'b0;
      upd_tgl <= 1'b0;
    end else begin
      mode_drive <= op_extest | op_clamp;
      mode_hiz <= op_highz;
      if (sel_bsr && upd_dr) begin
        upd_tgl <= ~upd_tgl;
      end
    end
  end

  logic drv_s1;
  logic drv_s2;
  logic hiz_s1;
  logic hiz_s2;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_s1 <= 1'b0;
      drv_s2 <= 1'b0;
      hiz_s1 <= 1'b0;
      hiz_s2 <= 1'b0;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      drv_s1 <= mode_drive;
      drv_s2 <= drv_s1;
      hiz_s1 <= mode_hiz;
      hiz_s2 <= hiz_s1;
      tgl_s1 <= upd_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // Latch is stable long after the toggle, so the word is safe to take
  wire upd_seen = tgl_s2 ^ tgl_s3;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_data_o <= '0;
    end else if (upd_seen) begin
      pin_data_o <= bsr_par;
    end
  end

  // Functional logic keeps running unless a test mode takes the pins
  assign pin_drive_o = drv_s2;
  assign pin_highz_o = hiz_s2;

  // ****************************************
  // Checks
  // ****************************************
  a_tlr_hold: assert property (@(posedge test_clock) disable iff (!tap_rst_n)
    (in_tlr && tms) |=> in_tlr)
    else $error("reset state left with mode select high");

  a_rti_leave: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    (state == jtt_pkg::JTT_RTI && tms && !fss_s2)
    |=> state == jtt_pkg::JTT_SEL_DR)
    else $error("idle did not move to select-DR");

  a_seldr_capture: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    (state == jtt_pkg::JTT_SEL_DR && !tms && !fss_s2) |=> cap_dr)
    else $error("select-DR did not enter capture");

  a_exit1dr_branch: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    (state == jtt_pkg::JTT_EX1_DR && !fss_s2)
    |=> ($past(tms) ? upd_dr : state == jtt_pkg::JTT_PA_DR))
    else $error("exit1-DR took wrong branch");

  a_pause_dr_hold: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    (state == jtt_pkg::JTT_PA_DR && !tms && !fss_s2) [*2]
    |=> state == jtt_pkg::JTT_PA_DR && $stable(byp))
    else $error("pause-DR did not hold");

  a_exit2ir_branch: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    (state == jtt_pkg::JTT_EX2_IR && !fss_s2)
    |=> ($past(tms) ? upd_ir : sh_ir))
    else $error("exit2-IR took wrong branch");

  a_capir_pattern: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    cap_ir |=> ir_shift == `JTT_IR_CAPTURE)
    else $error("capture-IR pattern wrong");

  a_shift_ir_data: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    sh_ir |=> ir_shift ==
      {$past(test_serial_in), $past(ir_shift[`JTT_IR_W-1:1])})
    else $error("instruction shift wrong");

  a_rti_idle_hold: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    state == jtt_pkg::JTT_RTI
    |=> $stable(ir_shift) && $stable(byp) && $stable(id_shift))
    else $error("test registers moved in idle");

  a_id_capture: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    (cap_dr && sel_id) |=> id_shift[0] == 1'b1 &&
      id_shift == id_value)
    else $error("identification capture wrong");

  a_strap_park: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    fss_s2 |=> in_tlr)
    else $error("port not parked with strap high");

  a_tlr_idcode: assert property (@(posedge test_clock)
    disable iff (!tap_rst_n)
    (in_tlr [*2]) |-> ir_cur == `JTT_IR_IDCODE)
    else $error("reset state lost IDCODE");

endmodule
`default_nettype wire

//--- jtt_tester.sv
// Boundary-scan tester model driving the far side of the test link
`timescale 1ns/1ps
`default_nettype none

module jtt_tester (
  // Test link
  output logic test_clock_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_en_n_i
);
  logic t;
  logic en_seen;

  initial begin
    test_clock_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // ****************************************
  // Link cycles
  // ****************************************
  // Clock stands still between calls; tdo and enable taken before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #24;
    tdo = tdo_i;
    en_seen = !tdo_en_n_i;
    test_clock_o = 1'b1;
    #24;
    test_clock_o = 1'b0;
  endtask

  // Scan from idle and back; pause_at detours via pause and exit2
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
      input int pause_at, output logic [31:0] dout, output logic en_low);
    int i;
    dout = '0;
    en_low = 1'b0;
    tick(1'b1, 1'($urandom), t);
    if (ir) begin
      tick(1'b1, 1'($urandom), t);
    end
    tick(1'b0, 1'($urandom), t);
    tick(1'b0, 1'($urandom), t);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1 || i == pause_at, din[i], dout[i]);
      // Enable is read settled, half a clock after its launching edge
      if (i == 0) begin
        en_low = en_seen;
      end
      if (i == pause_at && i != n - 1) begin
        tick(1'b0, 1'($urandom), t);
        tick(1'b0, 1'($urandom), t);
        tick(1'b0, 1'($urandom), t);
        tick(1'b1, 1'($urandom), t);
        tick(1'b0, 1'($urandom), t);
      end
    end
    tick(1'b1, 1'($urandom), t);
    tick(1'b0, 1'($urandom), t);
  endtask
endmodule

`default_nettype wire

//--- tb.sv
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin compares++; if ((got) !== (exp)) begin \
  fail_count++; $display("BAD %s exp %h got %h", name, exp, got); end end

module tb;
  localparam int BW = 16;
  // Identification values, arbitrary
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] PART = 16'hc0de;
  localparam logic [10:0] MAKER = 11'h155;
  localparam logic [31:0] ID = {VER, PART, MAKER, 1'b1};

  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic test_reset_n = 1'b0;
  logic fss = 1'b0;
  logic [BW-1:0] pin_sample = '0;
  wire logic test_clock;
  wire logic tms;
  wire logic tdi;
  wire logic tdo;
  wire logic en_n;
  wire logic [BW-1:0] pin_data;
  wire logic drive;
  wire logic highz;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  logic t;
  logic en_low;
  logic [31:0] dout;
  logic [31:0] din;
  logic [2:0] codes [5] = '{3'h7, 3'h3, 3'h4, 3'h5, 3'h6};

  jtt_tap #(.BSR_W(BW), .ID_VERSION(VER), .ID_PART(PART),
      .ID_MAKER(MAKER)) jtt_tap_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .test_clock(test_clock),
    .test_reset_n(test_reset_n), .test_mode_select(tms),
    .test_serial_in(tdi), .test_serial_out_o(tdo),
    .test_serial_out_en_n_o(en_n), .feature_set_select_i(fss),
    .pin_sample_i(pin_sample), .pin_data_o(pin_data),
    .pin_drive_o(drive), .pin_highz_o(highz));

  jtt_tester jtt_tester_i (.test_clock_o(test_clock), .tms_o(tms),
    .tdi_o(tdi), .tdo_i(tdo), .tdo_en_n_i(en_n));

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Scans take about two thousand cycles; this is well clear of that
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] byp(input logic [31:0] d);
    return {d[30:0], 1'b0} & 32'hff;
  endfunction

  task automatic ir_load(input logic [2:0] code, input int p);
    jtt_tester_i.scan(1'b1, 3, {29'h0, code}, p, dout, en_low);
    `CHK("ir capture", 32'h1, dout)
    `CHK("ir enable", 1'b1, en_low)
  endtask

  // Five highs land in reset from anywhere, then one low to idle
  task automatic to_idle();
    repeat (5) jtt_tester_i.tick(1'b1, 1'($urandom), t);
    jtt_tester_i.tick(1'b0, 1'($urandom), t);
  endtask

  task automatic check_id();
    jtt_tester_i.scan(1'b0, 32, $urandom, 10, dout, en_low);
    `CHK("idcode", ID, dout)
    `CHK("dr enable", 1'b1, en_low)
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h25e44ad0));
    repeat (16) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    test_reset_n = 1'b1;
    to_idle();
    check_id();
    foreach (codes[k]) begin
      ir_load(codes[k], -1);
      repeat (8) @(negedge ref_clk_i);
      `CHK("drive", codes[k] == 3'h3, drive)
      `CHK("highz", codes[k] == 3'h4, highz)
      din = $urandom;
      jtt_tester_i.scan(1'b0, 8, din, 3, dout, en_low);
      `CHK("bypass", byp(din), dout)
    end
    @(negedge ref_clk_i);
    pin_sample = BW'($urandom);
    ir_load(3'h2, 1);
    din = $urandom;
    jtt_tester_i.scan(1'b0, BW, din, 5, dout, en_low);
    `CHK("sample", {16'h0, pin_sample}, dout)
    repeat (8) @(negedge ref_clk_i);
    `CHK("pin data", din[BW-1:0], pin_data)
    `CHK("sample drive", 1'b0, drive)
    ir_load(3'h0, -1);
    repeat (8) @(negedge ref_clk_i);
    `CHK("extest drive", 1'b1, drive)
    `CHK("extest data", din[BW-1:0], pin_data)
    to_idle();
    check_id();
    ir_load(3'h7, -1);
    @(negedge ref_clk_i);
    test_reset_n = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    test_reset_n = 1'b1;
    to_idle();
    check_id();
    @(negedge ref_clk_i);
    fss = 1'b1;
    to_idle();
    jtt_tester_i.scan(1'b1, 3, 32'h7, -1, dout, en_low);
    `CHK("disabled enable", 1'b0, en_low)
    @(negedge ref_clk_i);
    fss = 1'b0;
    to_idle();
    check_id();
    results();
  end
endmodule

`default_nettype wire
